// *** rtl/ocbs_regs.v ***
// Calibration count, stored settings, one-time-programmable write and self-test registers.
//
// Notes on behaviour
// - Calibration counter result is a read-only 24-bit picosecond value, uncorrected.
// - Stored settings readback shows fine, coarse low, gain, bypass and bias fields.
// - Readback bit 14 shows the stored top coarse range bit.
// - Readback bit 15 shows the stored input impedance select.
// - Stored values take effect only with bit 13 set; otherwise reg 01 bit 0 overridden.
// - Memory programming allowed only while enable bit 0 is set; resets to zero.
// - A 4-bit address, reset zero, picks the memory bit the next strobe sets.
// - A write to the strobe register fires programming while enabled and no fuse is being blown; its contents stay reserved.
// - Self-test enable bit 0 puts calibration engine in self-test mode; resets zero.
// - Self-test signature reads as a 16-bit value in bits 15..0, reset zero.
// - Busy bit 16 stays high until the self-test completes; signature invalid meanwhile.
// - A write to the calibration strobe while idle starts calibration, or self-test when enabled.
// - Status bits 4 and 5 show calibration active and memory programming active.
`include "ocbs_defs.vh"

module ocbs_regs
#(
	parameter [11:0] PROG_CYCLES = `OCBS_NVM_PROG_CYCLES,
	parameter [11:0] ST_STEPS = `OCBS_ST_STEPS,
	parameter [11:0] CAL_MAX = `OCBS_CAL_MAX_CYCLES
)
(
	// Clock and reset.
	input wire i_sys_clk,
	input wire i_sys_rst,
	// Serial port pins.
	input wire i_spi_sclk,
	input wire i_spi_sen_n,
	input wire i_spi_sdi,
	output wire o_spi_sdo,
	output wire o_spi_sdo_oe,
	// Lower register block.
	output reg o_low_wr,
	output reg [`OCBS_ADDR_W-1:0] o_low_addr,
	output reg [`OCBS_DATA_W-1:0] o_low_wdata,
	input wire [`OCBS_DATA_W-1:0] i_low_rdata,
	input wire [14:0] i_clk_period_ps,
	output reg o_low_b0_override,
	// Calibration engine.
	input wire i_rc_cmp,
	output reg o_cal_start,
	output reg o_cal_busy,
	output reg [`OCBS_DATA_W-1:0] o_cal_count,
	output reg o_selftest_mode_on,
	output reg o_selftest_busy,
	// Non-volatile memory.
	output reg [`OCBS_NVM_BITS-1:0] o_stored_settings,
	output reg o_stored_valid,
	output reg o_nvm_write_active,
	output reg o_nvm_fuse_pulse,
	output reg [`OCBS_NVM_ADDR_W-1:0] o_nvm_fuse_addr
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_MEAS = 3'b010;
	localparam [2:0] ST_TEST = 3'b100;

	wire [`OCBS_ADDR_W-1:0] bus_addr;
	wire bus_rd_req;
	wire bus_wr;
	wire [`OCBS_DATA_W-1:0] bus_wdata;
	reg [`OCBS_DATA_W-1:0] next_rdata;
	reg nvm_program_en;
	reg [`OCBS_NVM_ADDR_W-1:0] nvm_program_address;
	reg [`OCBS_NVM_BITS-1:0] nvm_bits;
	reg [11:0] prog_cnt;
	reg [`OCBS_SIG_W-1:0] selftest_signature;
	reg [2:0] cal_state;
	reg [11:0] step_cnt;
	reg cmp_m;
	reg cmp_s;
	wire [24:0] count_sum;
	wire crc_fb;
	wire wr_cal;
	wire wr_nvm_strobe;
	wire fuse_done;

	ocbs_spi_frame u_frame
	(
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_spi_sclk(i_spi_sclk),
		.i_spi_sen_n(i_spi_sen_n),
		.i_spi_sdi(i_spi_sdi),
		.o_sdo(o_spi_sdo),
		.o_sdo_oe(o_spi_sdo_oe),
		.o_addr(bus_addr),
		.o_rd_req(bus_rd_req),
		.i_rdata(next_rdata),
		.o_wr(bus_wr),
		.o_wdata(bus_wdata)
	);

	assign wr_cal = bus_wr && bus_addr == `OCBS_REG_CAL_STROBE;
	assign wr_nvm_strobe = bus_wr && bus_addr == `OCBS_REG_NVM_STROBE;
	assign fuse_done = o_nvm_fuse_pulse && prog_cnt == PROG_CYCLES - 12'h001;
	assign count_sum = {1'b0, o_cal_count} + {10'h000, i_clk_period_ps};
	assign crc_fb = selftest_signature[15] ^ o_cal_count[0];

	// Read data is loaded into the frame receiver two cycles after the address is known.
	always @*
	begin
		next_rdata = 24'h00_0000;
		case (bus_addr)
			`OCBS_REG_CAL_STATUS:
			begin
				next_rdata = i_low_rdata;
				next_rdata[`OCBS_STAT_CAL_BUSY_BIT] = o_cal_busy;
				next_rdata[`OCBS_STAT_NVM_BUSY_BIT] = o_nvm_write_active;
			end
			`OCBS_REG_CAL_COUNT: next_rdata = o_cal_count;
			`OCBS_REG_STORED: next_rdata = {8'h00, nvm_bits};
			`OCBS_REG_NVM_EN: next_rdata = {23'h00_0000, nvm_program_en};
			`OCBS_REG_NVM_ADDR: next_rdata = {20'h0_0000, nvm_program_address};
			`OCBS_REG_NVM_STROBE: next_rdata = 24'h00_0000;
			`OCBS_REG_ST_EN: next_rdata = {23'h00_0000, o_selftest_mode_on};
			`OCBS_REG_ST_RESULT: next_rdata = {7'h00, o_selftest_busy, selftest_signature};
			default:
			begin
				if (bus_addr < `OCBS_REG_CAL_STATUS)
					next_rdata = i_low_rdata;
				else
					next_rdata = 24'h00_0000;
			end
		endcase
	end

	// Writes up to and including the status register are handed on; the reserved range ignores writes.
	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_low_wr <= 1'b0;
			o_low_addr <= 5'h00;
			o_low_wdata <= 24'h00_0000;
			nvm_program_en <= `OCBS_RST_NVM_EN;
			nvm_program_address <= `OCBS_RST_NVM_ADDR;
			o_selftest_mode_on <= `OCBS_RST_ST_EN;
		end
		else
		begin
			o_low_wr <= bus_wr && bus_addr <= `OCBS_REG_CAL_STATUS;
			if (bus_wr)
			begin
				o_low_addr <= bus_addr;
				o_low_wdata <= bus_wdata;
			end
			if (bus_wr && bus_addr == `OCBS_REG_NVM_EN)
				nvm_program_en <= bus_wdata[0];
			if (bus_wr && bus_addr == `OCBS_REG_NVM_ADDR)
				nvm_program_address <= bus_wdata[`OCBS_NVM_ADDR_W-1:0];
			if (bus_wr && bus_addr == `OCBS_REG_ST_EN)
				o_selftest_mode_on <= bus_wdata[0];
		end
	end

	// The address is latched at the strobe so a later address write cannot
	// redirect a fuse that is already being blown.
	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_nvm_fuse_pulse <= 1'b0;
			o_nvm_fuse_addr <= 4'h0;
			o_nvm_write_active <= 1'b0;
			prog_cnt <= 12'h000;
		end
		else
		begin
			if (wr_nvm_strobe && nvm_program_en && !o_nvm_fuse_pulse)
			begin
				o_nvm_fuse_pulse <= 1'b1;
				o_nvm_fuse_addr <= nvm_program_address;
				prog_cnt <= 12'h000;
			end
			else if (fuse_done)
				o_nvm_fuse_pulse <= 1'b0;
			else if (o_nvm_fuse_pulse)
				prog_cnt <= prog_cnt + 12'h001;
			o_nvm_write_active <= (o_nvm_fuse_pulse && !fuse_done) ||
				(wr_nvm_strobe && nvm_program_en);
		end
	end

	// Fuses only ever go from zero to one, so each cell is a set-only flop.
	genvar gi;
	generate
		for (gi = 0; gi < `OCBS_NVM_BITS; gi = gi + 1)
		begin : g_fuse
			always @(posedge i_sys_clk)
			begin
				if (i_sys_rst)
					nvm_bits[gi] <= 1'b0;
				else if (fuse_done && o_nvm_fuse_addr == gi)
					nvm_bits[gi] <= 1'b1;
			end
		end
	endgenerate

	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			o_stored_settings <= 16'h0000;
			o_stored_valid <= 1'b0;
			o_low_b0_override <= 1'b1;
		end
		else
		begin
			// coarse msb and impedance bits ride in the same word.
			o_stored_settings <= nvm_bits;
			o_stored_valid <= nvm_bits[`OCBS_STORED_VALID_BIT];
			o_low_b0_override <= ~nvm_bits[`OCBS_STORED_VALID_BIT];
		end
	end

	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			cmp_m <= 1'b0;
			cmp_s <= 1'b0;
		end
		else
		begin
			cmp_m <= i_rc_cmp;
			cmp_s <= cmp_m;
		end
	end

	// A strobe while a cycle runs is ignored rather than restarting the count.
	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			cal_state <= ST_IDLE;
			step_cnt <= 12'h000;
			o_cal_count <= `OCBS_RST_COUNT;
			o_cal_start <= 1'b0;
			o_cal_busy <= 1'b0;
			o_selftest_busy <= 1'b0;
			selftest_signature <= `OCBS_RST_SIG;
		end
		else
		begin
			o_cal_start <= 1'b0;
			case (cal_state)
				ST_IDLE:
				begin
					if (wr_cal)
					begin
						o_cal_start <= 1'b1;
						o_cal_count <= `OCBS_RST_COUNT;
						step_cnt <= 12'h000;
						o_cal_busy <= 1'b1;
						if (o_selftest_mode_on)
						begin
							cal_state <= ST_TEST;
							o_selftest_busy <= 1'b1;
							selftest_signature <= `OCBS_CRC_SEED;
						end
						else
							cal_state <= ST_MEAS;
					end
				end
				ST_MEAS:
				begin
					step_cnt <= step_cnt + 12'h001;
					// count picoseconds until the comparator trips.
					if (cmp_s || count_sum[24] || step_cnt == CAL_MAX - 12'h001)
					begin
						cal_state <= ST_IDLE;
						o_cal_busy <= 1'b0;
					end
					if (!cmp_s && !count_sum[24])
						o_cal_count <= count_sum[23:0];
				end
				ST_TEST:
				begin
					step_cnt <= step_cnt + 12'h001;
					o_cal_count <= count_sum[23:0];
					if (crc_fb)
						selftest_signature <= {selftest_signature[14:0], 1'b0} ^ `OCBS_CRC_POLY;
					else
						selftest_signature <= {selftest_signature[14:0], 1'b0};
					if (step_cnt == ST_STEPS - 12'h001)
					begin
						cal_state <= ST_IDLE;
						o_cal_busy <= 1'b0;
						o_selftest_busy <= 1'b0;
					end
				end
				default:
				begin
					cal_state <= ST_IDLE;
					o_cal_busy <= 1'b0;
					o_selftest_busy <= 1'b0;
				end
			endcase
		end
	end

endmodule // ocbs_regs

// *** pkg/ocbs_defs.vh ***
// Register offsets, field positions, reset values and timing counts of the register block.
`ifndef OCBS_DEFS_VH
`define OCBS_DEFS_VH

`define OCBS_ADDR_W 5
`define OCBS_DATA_W 24
`define OCBS_FRAME_BITS 5'h1e
`define OCBS_ADDR_LAST_BIT 5'h05

`define OCBS_REG_CAL_STATUS 5'h08
`define OCBS_REG_CAL_STROBE 5'h04
`define OCBS_REG_CAL_COUNT 5'h09
`define OCBS_REG_STORED 5'h0a
`define OCBS_REG_NVM_EN 5'h0b
`define OCBS_REG_NVM_ADDR 5'h0c
`define OCBS_REG_NVM_STROBE 5'h0d
`define OCBS_REG_ST_EN 5'h0e
`define OCBS_REG_ST_RESULT 5'h0f
`define OCBS_REG_RSVD_FIRST 5'h10
`define OCBS_REG_RSVD_LAST 5'h1a

`define OCBS_STAT_CAL_BUSY_BIT 4
`define OCBS_STAT_NVM_BUSY_BIT 5
`define OCBS_STORED_VALID_BIT 13
`define OCBS_STORED_MSB_COARSE_BIT 14
`define OCBS_STORED_ZIN_BIT 15
`define OCBS_ST_BUSY_BIT 16

`define OCBS_NVM_BITS 16
`define OCBS_NVM_ADDR_W 4
`define OCBS_SIG_W 16

`define OCBS_RST_NVM_EN 1'b0
`define OCBS_RST_NVM_ADDR 4'h0
`define OCBS_RST_ST_EN 1'b0
`define OCBS_RST_SIG 16'h0000
`define OCBS_RST_COUNT 24'h00_0000
`define OCBS_CRC_SEED 16'hffff
`define OCBS_CRC_POLY 16'h1021

`define OCBS_CLK_PERIOD_NS 8
`define OCBS_NVM_PROG_TIME_NS 1000
`define OCBS_NVM_PROG_CYCLES ((`OCBS_NVM_PROG_TIME_NS + `OCBS_CLK_PERIOD_NS - 1) / `OCBS_CLK_PERIOD_NS)
`define OCBS_ST_STEPS 256
`define OCBS_CAL_MAX_CYCLES 4000

`endif

// *** rtl/ocbs_spi_frame.v ***
// Serial port frame receiver and read data shifter on the system clock.
`include "ocbs_defs.vh"

module ocbs_spi_frame
(
	// Clock and reset.
	input wire i_sys_clk,
	input wire i_sys_rst,
	// Serial pins.
	input wire i_spi_sclk,
	input wire i_spi_sen_n,
	input wire i_spi_sdi,
	output reg o_sdo,
	output reg o_sdo_oe,
	// Register side.
	output reg [`OCBS_ADDR_W-1:0] o_addr,
	output reg o_rd_req,
	input wire [`OCBS_DATA_W-1:0] i_rdata,
	output reg o_wr,
	output reg [`OCBS_DATA_W-1:0] o_wdata
);

	reg sclk_m;
	reg sclk_s;
	reg sclk_d;
	reg sen_m;
	reg sen_s;
	reg sen_d;
	reg sdi_m;
	reg sdi_s;
	reg [4:0] bit_cnt;
	reg [28:0] shift_in;
	reg is_read;
	reg load_out;
	reg [`OCBS_DATA_W-1:0] shift_out;
	wire sclk_rise;
	wire sclk_fall;

	assign sclk_rise = sclk_s & ~sclk_d;
	assign sclk_fall = ~sclk_s & sclk_d;

	// Pins are asynchronous, so the serial clock is oversampled; it must stay
	// high and low for at least four system clocks.
	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			sen_m <= 1'b1;
			sen_s <= 1'b1;
			sen_d <= 1'b1;
			sdi_m <= 1'b0;
			sdi_s <= 1'b0;
		end
		else
		begin
			sclk_m <= i_spi_sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			sen_m <= i_spi_sen_n;
			sen_s <= sen_m;
			sen_d <= sen_s;
			sdi_m <= i_spi_sdi;
			sdi_s <= sdi_m;
		end
	end

	always @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
		begin
			bit_cnt <= 5'h00;
			shift_in <= 29'h0;
			is_read <= 1'b0;
			o_addr <= 5'h00;
			o_rd_req <= 1'b0;
			load_out <= 1'b0;
			o_wr <= 1'b0;
			o_wdata <= 24'h00_0000;
			shift_out <= 24'h00_0000;
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
		end
		else
		begin
			o_rd_req <= 1'b0;
			o_wr <= 1'b0;
			load_out <= o_rd_req;
			if (load_out)
			begin
				shift_out <= i_rdata;
				o_sdo_oe <= 1'b1;
			end
			if (sen_s)
			begin
				bit_cnt <= 5'h00;
				o_sdo_oe <= 1'b0;
				// A write takes effect only for a complete frame; short or long ones are dropped.
				if (!sen_d && bit_cnt == `OCBS_FRAME_BITS && !is_read)
				begin
					o_wr <= 1'b1;
					o_wdata <= shift_in[23:0];
				end
			end
			else if (sclk_rise)
			begin
				shift_in <= {shift_in[27:0], sdi_s};
				if (bit_cnt != 5'h1f)
					bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == 5'h00)
					is_read <= sdi_s;
				if (bit_cnt == `OCBS_ADDR_LAST_BIT)
				begin
					o_addr <= {shift_in[3:0], sdi_s};
					o_rd_req <= is_read;
				end
			end
			else if (sclk_fall && o_sdo_oe && !load_out)
			begin
				o_sdo <= shift_out[23];
				shift_out <= {shift_out[22:0], 1'b0};
			end
		end
	end

endmodule // ocbs_spi_frame

// *** verification/ocbs_spi_host.sv ***
// Serial port host model that frames register reads and writes.
module ocbs_spi_host
(
	// Clock.
	input logic i_clk,
	// Serial pins.
	output logic o_sclk,
	output logic o_sen_n,
	output logic o_sdi,
	input logic i_sdo,
	input logic i_sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_sclk = 1'b0;
		o_sen_n = 1'b1;
		o_sdi = 1'b0;
	end
	// Data in toggles where the device ignores it, so a stale level never passes.
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [23:0] wd,
		output logic [23:0] q);
		logic [29:0] f;
		int i;
		f = {rd, a, wd};
		q = 24'h00_0000;
		@(negedge i_clk);
		o_sen_n = 1'b0;
		for (i = 29; i >= 0; i--)
		begin
			o_sdi = (rd && i < 24) ? ~o_sdi : f[i];
			repeat (8) @(negedge i_clk);
			if (i < 24)
				q = {q[22:0], i_sdo_oe ? i_sdo : 1'bx};
			o_sclk = 1'b1;
			repeat (8) @(negedge i_clk);
			o_sclk = 1'b0;
		end
		repeat (8) @(negedge i_clk);
		o_sen_n = 1'b1;
		o_sdi = ~o_sdi;
		repeat (12) @(negedge i_clk);
	endtask
endmodule // ocbs_spi_host

// *** verification/ocbs_regs_assertions.sv ***
// Concurrent checks on the register block ports.
module ocbs_regs_checker
#(
	parameter [11:0] PROG_CYCLES = 12'h07d,
	parameter [11:0] ST_STEPS = 12'h100
)
(
	input logic i_sys_clk,
	input logic i_sys_rst,
	input logic o_low_b0_override,
	input logic o_cal_start,
	input logic o_cal_busy,
	input logic o_selftest_mode_on,
	input logic o_selftest_busy,
	input logic [15:0] o_stored_settings,
	input logic o_stored_valid,
	input logic o_nvm_write_active,
	input logic o_nvm_fuse_pulse,
	input logic [3:0] o_nvm_fuse_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic [11:0] st_n;
	logic [11:0] pf_n;
	always @(posedge i_sys_clk)
	begin
		st_n <= (i_sys_rst || !o_selftest_busy) ? 12'h000 : st_n + 12'h001;
		pf_n <= (i_sys_rst || !o_nvm_fuse_pulse) ? 12'h000 : pf_n + 12'h001;
	end
	sequence s_fuse_done;
		o_nvm_fuse_pulse ##1 !o_nvm_fuse_pulse;
	endsequence
	a_override_follows_valid: assert property (o_stored_valid |-> ##[0:2] !o_low_b0_override)
		else $error("override still set with valid flag");
	a_start_one_pulse: assert property (o_cal_start |=> !o_cal_start)
		else $error("start pulse longer than one cycle");
	a_start_sets_busy: assert property (o_cal_start |-> ##[0:1] o_cal_busy)
		else $error("start without busy");
	a_selftest_in_cal: assert property (o_selftest_busy |-> o_cal_busy && o_selftest_mode_on)
		else $error("self-test busy outside self-test calibration");
	a_selftest_length: assert property ($fell(o_selftest_busy) |-> st_n == ST_STEPS)
		else $error("self-test busy length wrong");
	a_fuse_pulse_length: assert property (s_fuse_done |-> pf_n == PROG_CYCLES)
		else $error("fuse pulse length wrong");
	a_fuse_shows_active: assert property (o_nvm_fuse_pulse |-> o_nvm_write_active)
		else $error("fuse pulse without active flag");
	a_fuse_sets_bit: assert property (s_fuse_done |-> ##[1:2] o_stored_settings[o_nvm_fuse_addr])
		else $error("addressed fuse bit not set");
	a_fuse_addr_held: assert property (o_nvm_fuse_pulse && $past(o_nvm_fuse_pulse)
		|-> $stable(o_nvm_fuse_addr))
		else $error("fuse address moved during pulse");
endmodule // ocbs_regs_checker

// *** verification/ocbs_regs_tb.sv ***
// Self-checking bench for the register block.
module ocbs_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmp = 1'b0;
	logic [23:0] q;
	logic [23:0] fz = 24'h00_0000;
	logic [23:0] lrd = 24'ha5_0036;
	logic [23:0] lwr_n = 24'h00_0000;
	wire lwr;
	wire [4:0] lad;
	wire [23:0] lwd, ccnt;
	logic [4:0] ra [8] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10};
	logic [3:0] fa [4] = '{4'h5, 4'hd, 4'he, 4'hf};
	wire sclk, sen_n, sdi, sdo, oe, ovr, mode;
	int bad_count = 0;
	int check_count = 0;
	initial forever #4 clk = ~clk;
	ocbs_spi_host host (.i_clk(clk), .o_sclk(sclk), .o_sen_n(sen_n), .o_sdi(sdi),
		.i_sdo(sdo), .i_sdo_oe(oe));
	// Long programming and measuring times let a status read land while they run.
	ocbs_regs #(.PROG_CYCLES(12'h200), .ST_STEPS(12'h008), .CAL_MAX(12'h100)) uut (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_spi_sclk(sclk), .i_spi_sen_n(sen_n),
		.i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .o_low_wr(lwr), .o_low_addr(lad),
		.o_low_wdata(lwd), .i_low_rdata(lrd), .i_clk_period_ps(15'h0064),
		.o_low_b0_override(ovr), .i_rc_cmp(cmp), .o_cal_start(), .o_cal_busy(),
		.o_cal_count(ccnt), .o_selftest_mode_on(mode), .o_selftest_busy(),
		.o_stored_settings(), .o_stored_valid(), .o_nvm_write_active(),
		.o_nvm_fuse_pulse(), .o_nvm_fuse_addr());
	always @(negedge clk)
		if (lwr === 1'b1)
			lwr_n <= lwr_n + 24'h00_0001;
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk24(input logic [23:0] g, input logic [23:0] e);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk1(input logic g, input logic e);
		chk24({23'h00_0000, g}, {23'h00_0000, e});
	endtask
	task wr(input logic [4:0] a, input logic [23:0] d);
		host.xfer(1'b0, a, d, q);
	endtask
	task rchk(input logic [4:0] a, input logic [23:0] e);
		host.xfer(1'b1, a, 24'h00_0000, q);
		chk24(q, e);
	endtask
	// Status polling is bounded so a stuck flag ends the run.
	task wait_idle(input int b);
		int i;
		q = 24'hff_ffff;
		for (i = 0; i < 20 && q[b] !== 1'b0; i++)
			host.xfer(1'b1, 5'h08, 24'h00_0000, q);
		if (q[b] !== 1'b0)
		begin
			bad_count++;
			stop_test;
		end
	endtask
	// Count stays even, so only zero bits enter the signature.
	function automatic logic [15:0] crc_zero(input int n);
		logic [15:0] c;
		c = 16'hffff;
		repeat (n) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
		return c;
	endfunction
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		stop_test;
	end
	initial
	begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk1(ovr, 1'b1);
		foreach (ra[i]) rchk(ra[i], 24'h00_0000);
		rchk(5'h08, 24'ha5_0006);
		$display("test reset done");
		wr(5'h0b, 24'hff_ffff);
		rchk(5'h0b, 24'h00_0001);
		foreach (fa[i])
		begin
			wr(5'h0c, {20'h0_0000, fa[i]});
			wr(5'h0d, 24'h00_a5a5);
			rchk(5'h08, 24'ha5_0026);
			wait_idle(5);
			fz[fa[i]] = 1'b1;
			rchk(5'h0a, fz);
		end
		rchk(5'h0c, 24'h00_000f);
		rchk(5'h0d, 24'h00_0000);
		chk1(ovr, 1'b0);
		wr(5'h0b, 24'h00_0000);
		wr(5'h0c, 24'h00_0000);
		wr(5'h0d, 24'h00_0000);
		rchk(5'h0a, fz);
		wr(5'h10, 24'hff_ffff);
		rchk(5'h10, 24'h00_0000);
		$display("test programming done");
		wr(5'h04, 24'h12_3456);
		rchk(5'h08, 24'ha5_0016);
		chk24({19'h0_0000, lad}, 24'h00_0004);
		chk24(lwd, 24'h12_3456);
		wait_idle(4);
		host.xfer(1'b1, 5'h09, 24'h00_0000, q);
		chk24(q, 24'h00_6400);
		chk24(ccnt, 24'h00_6400);
		cmp = 1'b1;
		wr(5'h04, 24'h00_0000);
		wait_idle(4);
		host.xfer(1'b1, 5'h09, 24'h00_0000, q);
		chk24(q, 24'h00_0000);
		cmp = 1'b0;
		$display("test calibration done");
		wr(5'h0e, 24'h00_0001);
		chk1(mode, 1'b1);
		wr(5'h04, 24'h00_0000);
		wait_idle(4);
		rchk(5'h0f, {8'h00, crc_zero(8)});
		rchk(5'h09, 24'h00_0320);
		wr(5'h0e, 24'h00_0000);
		chk1(mode, 1'b0);
		chk24(lwr_n, 24'h00_0003);
		$display("test self-test done");
		stop_test;
	end
endmodule // ocbs_regs_tb
bind ocbs_regs ocbs_regs_checker #(.PROG_CYCLES(PROG_CYCLES), .ST_STEPS(ST_STEPS)) u_chk (
	.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .o_low_b0_override(o_low_b0_override),
	.o_cal_start(o_cal_start), .o_cal_busy(o_cal_busy),
	.o_selftest_mode_on(o_selftest_mode_on), .o_selftest_busy(o_selftest_busy),
	.o_stored_settings(o_stored_settings), .o_stored_valid(o_stored_valid),
	.o_nvm_write_active(o_nvm_write_active), .o_nvm_fuse_pulse(o_nvm_fuse_pulse),
	.o_nvm_fuse_addr(o_nvm_fuse_addr));
